// >>> verilog/hpp_host_port.sv
// How it works
// [RL1] Two bytes make one sixteen-bit word.
// [RL2] Host sends first byte, then second, unbroken.
// [RL3] Control bit picks which byte is high.
// [RL4] Auto-increment: post on read, pre on write.
// [RL5] Selects reach control, pointer or data latch.
// [RL6] Host control write can interrupt processor.
// [RL7] Processor raises host interrupt; host clears it.
// [RL8] Control register also at processor address 0500h.
// [RL9] Pointer is host-only, addresses shared memory.
// [RL10] Data latch is host-only word holder.
// [RL11] Data transfers trigger shared memory access.
// [RL12] Host wins conflicts; processor stalls one cycle.
// [RL13] Host pins resynchronised to internal clock.
// [RL14] Host-only mode locks processor out of memory.
// [RL15] Shared mode: byte every five clocks.
// [RL16] Host-only mode: byte every 50 ns.
// [RL17] Ready output inserts wait states.
// [RL18] Host is master; device only responds.
// [RL19] Processor may use memory as ordinary storage.
// [RL20] Select codes: control, data-inc, pointer, data.
// [RL21] Ready low while busy, high without select.
// [RL22] Controls latched on address or data strobe.
// [RL23] Memory write only after second byte.
// [RL24] Read fetches word before first byte.
module hpp_host_port (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_port_chip_select_n,
	input  wire logic        i_data_strobe_one_n,
	input  wire logic        i_data_strobe_two_n,
	input  wire logic        i_addr_strobe_n,
	input  wire logic        i_byte_phase_input,
	input  wire logic        i_register_select_high,
	input  wire logic        i_register_select_low,
	input  wire logic        i_transfer_direction,
	input  wire logic [7:0]  i_host_byte_bus,
	output logic      [7:0]  o_host_byte_bus,
	output logic             o_host_byte_bus_oe_n,
	output logic             o_host_wait_ready,
	output logic             o_host_interrupt_out_n,
	input  wire logic        i_cpu_req,
	input  wire logic        i_cpu_we,
	input  wire logic [15:0] i_cpu_addr,
	input  wire logic [15:0] i_cpu_wdata,
	output logic      [15:0] o_cpu_rdata,
	output logic             o_cpu_rvalid,
	output logic             o_cpu_stall,
	output logic             o_cpu_interrupt
);
	import hpp_pkg::*;

	function automatic logic is_data(input logic [1:0] sel);
		return sel == SEL_DATA || sel == SEL_DATA_INC;
	endfunction

	// The high half is the first byte when the order bit is set.
	function automatic logic [7:0] get_byte(input logic [15:0] w, input logic ph,
		input logic bob);
		return (ph == !bob) ? w[15:8] : w[7:0];
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic [7:0] b,
		input logic ph, input logic bob);
		return (ph == !bob) ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	logic [PIN_W-1:0] pins_s;
	logic             s_cs_n, s_ds1_n, s_ds2_n, s_as_n, s_ph, s_rd;
	logic [1:0]       s_sel;
	logic [7:0]       s_d;
	logic             strobe_act, strobe_q, as_q, start, stop, as_fall, live, as_lat_r;
	logic             ph_r, rd_r, taken_r, acc_ok, cur_ph, cur_rd, take;
	logic [1:0]       sel_r, cur_sel;
	hpp_state_t       state_r, state_nxt;
	logic [PACE_W-1:0] pace_r, pace_nxt;
	logic [15:0]      ptr_r, latch_r, chold_r, hw, ctrl_word, ram_rdata, ram_wd;
	logic             bob_r, hom_r, wr_stop, host_ctrl_wr, cpu_ctrl_wr;
	logic             cpu_go, cpu_hit, host_acc, ram_en, ram_we;
	logic             rd_pend_r, rd_ctrl_r;
	logic [RAM_AW-1:0] ram_addr;

	// Every host pin crosses two flops before use; idle levels are all high.
	hpp_sync #(.W(PIN_W)) u_sync ( // RL13
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_async   ({i_port_chip_select_n, i_data_strobe_one_n, i_data_strobe_two_n,
			i_addr_strobe_n, i_byte_phase_input, i_register_select_high,
			i_register_select_low, i_transfer_direction, i_host_byte_bus}),
		.o_sync    (pins_s)
	);

	assign {s_cs_n, s_ds1_n, s_ds2_n, s_as_n, s_ph, s_sel, s_rd, s_d} = pins_s;

	// Strobes are exclusive-ORed, so both low does not enable a cycle.
	assign strobe_act = !s_cs_n && (s_ds1_n ^ s_ds2_n);
	assign start      = strobe_act && !strobe_q;
	assign stop       = !strobe_act && strobe_q;
	assign as_fall    = !s_as_n && as_q;
	assign live       = start && !as_lat_r;
	assign cur_ph     = live ? s_ph : ph_r;
	assign cur_sel    = live ? s_sel : sel_r;
	assign cur_rd     = live ? s_rd : rd_r;
	assign acc_ok     = state_r == ST_IDLE && pace_r == '0;
	assign take       = start && acc_ok; // RL18
	assign wr_stop    = stop && taken_r && !rd_r;

	// Edge history of the combined strobe and the address strobe. A host on a
	// multiplexed bus removes its controls after the address strobe, so once
	// that strobe has fallen the data strobe must not sample them again.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			strobe_q <= 1'b0;
			as_q     <= 1'b1;
			as_lat_r <= 1'b0;
		end else begin
			strobe_q <= strobe_act;
			as_q     <= s_as_n;
			as_lat_r <= as_fall || (as_lat_r && !stop); // RL22
		end
	end

	// Phase, select and direction are caught by the address strobe when it
	// is wired, else by the latest of chip select and the data strobes.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_r  <= 1'b0;
			sel_r <= SEL_CTRL;
			rd_r  <= 1'b1;
		end else if (as_fall || live) begin // RL22
			ph_r  <= s_ph;
			sel_r <= s_sel;
			rd_r  <= s_rd;
		end
	end

	// A cycle refused while busy is ignored at its end as well.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			taken_r <= 1'b0;
		end else if (take) begin
			taken_r <= 1'b1;
		end else if (stop) begin
			taken_r <= 1'b0;
		end
	end

	// Internal memory sequencing for data-latch cycles.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take && cur_rd && is_data(cur_sel) && !cur_ph) begin
					state_nxt = ST_FETCH; // RL24
				end else if (wr_stop && is_data(sel_r) && ph_r) begin
					state_nxt = ST_STORE; // RL23
				end
			end
			ST_FETCH: state_nxt = ST_LOAD;
			ST_LOAD:  state_nxt = ST_IDLE;
			ST_STORE: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Byte pacing: each accepted byte holds off the next for a fixed spacing.
	always_comb begin
		if (take) begin
			pace_nxt = hom_r ? HOM_PACE : SAM_PACE; // RL15 RL16
		end else if (pace_r != '0) begin
			pace_nxt = pace_r - PACE_W'(1);
		end else begin
			pace_nxt = '0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pace_r <= '0;
		end else begin
			pace_r <= pace_nxt;
		end
	end

	// Ready tracks internal work; without chip select it stays high.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_host_wait_ready <= 1'b1;
		end else begin
			o_host_wait_ready <= s_cs_n || (state_nxt == ST_IDLE && pace_nxt == '0); // RL17 RL21
		end
	end

	// Pointer: written a byte at a time, bumped on the second data-inc byte.
	// Bumping at the stop gives post-increment for reads and, since the
	// store runs a cycle later, pre-increment for writes.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ptr_r <= '0;
		end else if (wr_stop && sel_r == SEL_PTR) begin
			ptr_r <= put_byte(ptr_r, s_d, ph_r, bob_r); // RL9 RL20
		end else if (stop && taken_r && sel_r == SEL_DATA_INC && ph_r) begin
			ptr_r <= ptr_r + 16'h0001; // RL4
		end
	end

	// Data latch: loaded by a fetch or assembled from host bytes.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			latch_r <= '0;
		end else if (state_r == ST_LOAD) begin
			latch_r <= ram_rdata; // RL10
		end else if (wr_stop && is_data(sel_r)) begin
			latch_r <= put_byte(latch_r, s_d, ph_r, bob_r); // RL1 RL3
		end
	end

	// Read byte presented to the host, always from a flop.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_host_byte_bus <= '0;
		end else if (state_r == ST_LOAD) begin
			o_host_byte_bus <= get_byte(ram_rdata, 1'b0, bob_r); // RL24
		end else if (take && cur_rd) begin
			case (cur_sel) // RL5
				SEL_CTRL: o_host_byte_bus <= get_byte(ctrl_word, cur_ph, bob_r);
				SEL_PTR:  o_host_byte_bus <= get_byte(ptr_r, cur_ph, bob_r);
				default:  o_host_byte_bus <= get_byte(latch_r, cur_ph, bob_r);
			endcase
		end
	end

	// The bus is driven only during an accepted read strobe.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_host_byte_bus_oe_n <= 1'b1;
		end else begin
			o_host_byte_bus_oe_n <= !(strobe_act && (take ? cur_rd : taken_r && rd_r));
		end
	end

	// Control bytes are held until the pair is complete, then act together.
	assign hw           = put_byte(chold_r, s_d, ph_r, bob_r);
	assign host_ctrl_wr = wr_stop && sel_r == SEL_CTRL && ph_r;
	assign cpu_ctrl_wr  = cpu_go && i_cpu_we && i_cpu_addr == CTRL_ADDR; // RL8
	assign ctrl_word    = {12'h000, hom_r, !o_host_interrupt_out_n, o_cpu_interrupt, bob_r};

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			chold_r <= CTRL_RST;
		end else if (wr_stop && sel_r == SEL_CTRL) begin
			chold_r <= hw;
		end
	end

	// Order and mode bits; the host write wins a same-cycle collision.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			bob_r <= CTRL_RST[CTRL_BOB];
			hom_r <= CTRL_RST[CTRL_HOM];
		end else begin
			if (host_ctrl_wr) begin
				bob_r <= hw[CTRL_BOB]; // RL3
			end else if (cpu_ctrl_wr) begin
				bob_r <= i_cpu_wdata[CTRL_BOB];
			end
			if (cpu_ctrl_wr) begin
				hom_r <= i_cpu_wdata[CTRL_HOM];
			end
		end
	end

	// Interrupt flags: a set always beats a clear in the same cycle.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cpu_interrupt        <= CTRL_RST[CTRL_CPU_INT];
			o_host_interrupt_out_n <= !CTRL_RST[CTRL_HOST_INT];
		end else begin
			if (host_ctrl_wr && hw[CTRL_CPU_INT]) begin
				o_cpu_interrupt <= 1'b1; // RL6
			end else if (cpu_ctrl_wr && i_cpu_wdata[CTRL_CPU_INT]) begin
				o_cpu_interrupt <= 1'b0;
			end
			if (cpu_ctrl_wr && i_cpu_wdata[CTRL_HOST_INT]) begin
				o_host_interrupt_out_n <= 1'b0; // RL7
			end else if (host_ctrl_wr && hw[CTRL_HOST_INT]) begin
				o_host_interrupt_out_n <= 1'b1; // RL7
			end
		end
	end

	// Arbitration: a host slot owns the memory, and the stall was raised
	// one cycle ahead so the processor simply repeats its request.
	assign cpu_go   = i_cpu_req && !o_cpu_stall;
	assign cpu_hit  = i_cpu_addr[15:RAM_AW] == RAM_BASE[15:RAM_AW];
	assign host_acc = state_r == ST_FETCH || state_r == ST_STORE;
	assign ram_en   = host_acc || (cpu_go && cpu_hit); // RL11 RL19
	assign ram_we   = host_acc ? state_r == ST_STORE : i_cpu_we;
	assign ram_addr = host_acc ? ptr_r[RAM_AW-1:0] : i_cpu_addr[RAM_AW-1:0]; // RL12
	assign ram_wd   = host_acc ? latch_r : i_cpu_wdata;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cpu_stall <= 1'b0;
		end else begin
			o_cpu_stall <= hom_r || state_nxt == ST_FETCH || state_nxt == ST_STORE; // RL12 RL14
		end
	end

	hpp_ram u_ram (
		.i_clk_sys (i_clk_sys),
		.i_en      (ram_en),
		.i_we      (ram_we),
		.i_addr    (ram_addr),
		.i_wdata   (ram_wd),
		.o_rdata   (ram_rdata)
	);

	// Processor reads return two cycles after being accepted.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_pend_r    <= 1'b0;
			rd_ctrl_r    <= 1'b0;
			o_cpu_rvalid <= 1'b0;
			o_cpu_rdata  <= '0;
		end else begin
			rd_pend_r    <= cpu_go && !i_cpu_we && (cpu_hit || i_cpu_addr == CTRL_ADDR);
			rd_ctrl_r    <= i_cpu_addr == CTRL_ADDR;
			o_cpu_rvalid <= rd_pend_r;
			o_cpu_rdata  <= rd_ctrl_r ? ctrl_word : ram_rdata; // RL8
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence s_fetch;
		state_r == ST_FETCH ##1 state_r == ST_LOAD ##1 state_r == ST_IDLE;
	endsequence

	a_ready_idle_cs: assert property (s_cs_n |=> o_host_wait_ready) // RL21
		else $error("ready low without chip select");
	a_fetch_first: assert property ( // RL24
		state_r == ST_IDLE && take && cur_rd && is_data(cur_sel) && !cur_ph |=> s_fetch)
		else $error("first read byte not preceded by fetch");
	a_store_second: assert property ( // RL23
		state_r == ST_IDLE && wr_stop && is_data(sel_r) && ph_r |=> state_r == ST_STORE ##1
		state_r == ST_IDLE)
		else $error("second write byte did not store");
	a_host_wins: assert property (host_acc |-> o_cpu_stall && ram_en && ram_addr == // RL12
		ptr_r[RAM_AW-1:0])
		else $error("host slot not given the memory");
	a_auto_inc: assert property ( // RL4
		stop && taken_r && sel_r == SEL_DATA_INC && ph_r |=> ptr_r == $past(ptr_r) + 16'h0001)
		else $error("pointer not incremented");
	a_byte_pace: assert property (take && !hom_r |=> !o_host_wait_ready [*4]) // RL15
		else $error("byte spacing too short");
	a_cpu_irq: assert property (host_ctrl_wr && hw[CTRL_CPU_INT] |=> o_cpu_interrupt) // RL6
		else $error("host write did not interrupt processor");
	a_host_interrupt_out_ack: assert property ( // RL7
		host_ctrl_wr && hw[CTRL_HOST_INT] && !(cpu_ctrl_wr && i_cpu_wdata[CTRL_HOST_INT])
		|=> o_host_interrupt_out_n)
		else $error("host interrupt not cleared");
	a_hom_lock: assert property (hom_r |=> o_cpu_stall ##1 !ram_en || host_acc) // RL14
		else $error("processor reached memory in host-only mode");

endmodule // hpp_host_port

// >>> pkg/hpp_pkg.sv
package hpp_pkg;

	// Core clock and the byte pacing derived from it.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SAM_BYTE_CYC  = 5;
	localparam int unsigned HOM_BYTE_NS   = 50;
	localparam int unsigned HOM_BYTE_CYC  = (HOM_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PACE_W        = 3;
	localparam logic [PACE_W-1:0] SAM_PACE = PACE_W'(SAM_BYTE_CYC - 1);
	localparam logic [PACE_W-1:0] HOM_PACE = PACE_W'(HOM_BYTE_CYC - 1);

	// Processor data-space map.
	localparam logic [15:0] CTRL_ADDR = 16'h0500;
	localparam logic [15:0] RAM_BASE  = 16'h1000;
	localparam int unsigned RAM_AW    = 11;
	localparam int unsigned RAM_WORDS = 2048;

	// Register select codes on the two select pins.
	localparam logic [1:0] SEL_CTRL     = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_PTR      = 2'h2;
	localparam logic [1:0] SEL_DATA     = 2'h3;

	// Control register bit positions and reset value.
	localparam int unsigned CTRL_BOB      = 0;
	localparam int unsigned CTRL_CPU_INT  = 1;
	localparam int unsigned CTRL_HOST_INT = 2;
	localparam int unsigned CTRL_HOM      = 3;
	localparam logic [15:0] CTRL_RST      = 16'h0000;

	// Synchroniser width for the whole host pin group.
	localparam int unsigned PIN_W = 16;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_STORE} hpp_state_t;

endpackage

// >>> verilog/hpp_sync.sv
// Two-stage synchroniser for a group of asynchronous host pins.
module hpp_sync #(
	parameter int unsigned W = 16
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second; pins reset to their idle levels.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_r <= '1;
			o_sync <= '1;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule // hpp_sync

// >>> verilog/hpp_ram.sv
// Single-access shared word store with a registered read port.
module hpp_ram (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_en,
	input  wire logic                       i_we,
	input  wire logic [hpp_pkg::RAM_AW-1:0] i_addr,
	input  wire logic [15:0]                i_wdata,
	output logic      [15:0]                o_rdata
);
	import hpp_pkg::*;

	logic [15:0] mem [RAM_WORDS];

	// One access per cycle; the arbiter upstream decides who owns it.
	always_ff @(posedge i_clk_sys) begin
		if (i_en) begin
			if (i_we) begin
				mem[i_addr] <= i_wdata;
			end
			o_rdata <= mem[i_addr];
		end
	end
endmodule // hpp_ram

// >>> verification/hpp_host_model.sv
// Host-side master: drives the select, strobe and byte pins, and resolves the byte wire.
module hpp_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_dev_byte,
	input  wire logic       i_dev_oe_n,
	input  wire logic       i_ready,
	output logic            o_cs_n,
	output logic            o_ds1_n,
	output logic            o_ds2_n,
	output logic            o_bil,
	output logic            o_sel_h,
	output logic            o_sel_l,
	output logic            o_rw,
	output logic            o_as_n,
	output logic      [7:0] o_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] drv_dat;
	logic [7:0] last_q = 8'h00;
	logic       drv_en = 1'b0;
	logic       use_as = 1'b0;

	// Nobody driving leaves the wire moving, so a stale byte cannot pass as good data.
	assign o_bus = !i_dev_oe_n ? i_dev_byte : (drv_en ? drv_dat : ~last_q);
	always @(posedge i_clk_sys) last_q <= o_bus;

	// Pins idle and deselected from time zero.
	initial begin
		{o_cs_n, o_ds1_n, o_ds2_n, o_bil, o_sel_h, o_sel_l, o_rw} = 7'h78;
		o_as_n = 1'b1;
		drv_dat = 8'h00;
	end

	// One byte cycle; ok means ready was seen low and then high again in bounded time.
	task automatic xbyte(input logic [1:0] sel, input logic rd, input logic ph,
		input logic [7:0] b, output logic [7:0] got, output logic ok);
		logic low;
		int n;
		low = 1'b0;
		ok = 1'b0;
		@(negedge i_clk_sys);
		o_cs_n = 1'b0;
		{o_sel_h, o_sel_l} = sel;
		o_rw = rd;
		o_bil = ph;
		drv_en = !rd;
		drv_dat = b;
		o_as_n = !use_as;
		@(negedge i_clk_sys);
		// With the address strobe in use the controls are wrong by the data strobe.
		if (use_as) begin
			o_as_n = 1'b1;
			{o_sel_h, o_sel_l} = ~sel;
			o_rw = !rd;
			o_bil = !ph;
		end
		// Without the address strobe, controls settle a cycle before the data strobe that latches them.
		if (rd) o_ds2_n = 1'b0;
		else o_ds1_n = 1'b0;
		repeat (5) begin
			@(negedge i_clk_sys);
			if (i_ready === 1'b0) low = 1'b1;
		end
		for (n = 0; n < 40 && !ok; n++) begin
			if (i_ready === 1'b1) ok = low;
			else @(negedge i_clk_sys);
		end
		got = o_bus;
		o_ds1_n = 1'b1;
		o_ds2_n = 1'b1;
		@(negedge i_clk_sys);
		drv_en = 1'b0;
		repeat (6) @(negedge i_clk_sys);
		o_cs_n = 1'b1;
	endtask

	// A word is always two bytes, first then second, never broken off.
	task automatic word(input logic [1:0] sel, input logic rd, input logic bob,
		input logic [15:0] wd, output logic [15:0] got, output logic ok);
		logic [7:0] g0;
		logic [7:0] g1;
		logic       k0;
		logic       k1;
		xbyte(sel, rd, 1'b0, bob ? wd[15:8] : wd[7:0], g0, k0);
		xbyte(sel, rd, 1'b1, bob ? wd[7:0] : wd[15:8], g1, k1);
		got = bob ? {g0, g1} : {g1, g0};
		ok = k0 & k1;
	endtask
endmodule // hpp_host_model

// >>> verification/hpp_host_port_tb.sv
module hpp_host_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hpp_pkg::*;
	typedef struct packed {
		logic        cpu;
		logic [1:0]  sel;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wd;
		logic [15:0] exp;
	} hpp_row_t;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cs_n, ds1_n, ds2_n, bil, sel_h, sel_l, rw, oe_n, rdy, host_interrupt_out_n, as_n;
	logic        creq = 1'b0, cwe = 1'b0, rvalid, stall, cint, bob = 1'b0, ok;
	logic [7:0]  hbus, dbus;
	logic [15:0] caddr = 16'h0000, cwd = 16'h0000, crd, got;
	int          err_total = 0, comparisons = 0, cyc = 0, stalls = 0;
	// Columns: cpu, select, read, cpu address, write data, expected read data.
	hpp_row_t rows [19] = '{
		'{1'b0, SEL_CTRL, 1'b0, 16'h0000, 16'h0000, 16'h0000},
		'{1'b0, SEL_PTR, 1'b0, 16'h0000, 16'h0010, 16'h0000},
		'{1'b0, SEL_PTR, 1'b1, 16'h0000, 16'h0000, 16'h0010},
		'{1'b0, SEL_DATA, 1'b0, 16'h0000, 16'hA55A, 16'h0000},
		'{1'b0, SEL_DATA, 1'b1, 16'h0000, 16'h0000, 16'hA55A},
		'{1'b1, 2'h0, 1'b1, 16'h1010, 16'h0000, 16'hA55A},
		'{1'b0, SEL_DATA_INC, 1'b0, 16'h0000, 16'h1234, 16'h0000},
		'{1'b0, SEL_PTR, 1'b1, 16'h0000, 16'h0000, 16'h0011},
		'{1'b1, 2'h0, 1'b1, 16'h1011, 16'h0000, 16'h1234},
		'{1'b1, 2'h0, 1'b0, 16'h1012, 16'hC3E1, 16'h0000},
		'{1'b0, SEL_DATA_INC, 1'b1, 16'h0000, 16'h0000, 16'h1234},
		'{1'b0, SEL_DATA, 1'b1, 16'h0000, 16'h0000, 16'hC3E1},
		'{1'b0, SEL_CTRL, 1'b0, 16'h0000, 16'h0001, 16'h0000},
		'{1'b0, SEL_DATA_INC, 1'b0, 16'h0000, 16'h5AC3, 16'h0000},
		'{1'b1, 2'h0, 1'b1, 16'h1013, 16'h0000, 16'h5AC3},
		'{1'b0, SEL_PTR, 1'b0, 16'h0000, 16'h0813, 16'h0000},
		'{1'b0, SEL_DATA, 1'b1, 16'h0000, 16'h0000, 16'h5AC3},
		'{1'b1, 2'h0, 1'b1, 16'h0500, 16'h0000, 16'h0001},
		'{1'b0, SEL_CTRL, 1'b1, 16'h0000, 16'h0000, 16'h0001}};

	always #5 clk = ~clk;

	// Cycle ceiling well above the fewer than a thousand cycles the run needs.
	always @(posedge clk) begin
		cyc++;
		if (stall === 1'b1 && creq === 1'b1) stalls++;
		if (cyc == 8000) begin
			err_total++;
			report_and_stop();
		end
	end

	hpp_host_port dut (.i_clk_sys(clk), .i_rstn(rstn), .i_port_chip_select_n(cs_n),
		.i_data_strobe_one_n(ds1_n), .i_data_strobe_two_n(ds2_n), .i_addr_strobe_n(as_n),
		.i_byte_phase_input(bil), .i_register_select_high(sel_h),
		.i_register_select_low(sel_l), .i_transfer_direction(rw), .i_host_byte_bus(hbus),
		.o_host_byte_bus(dbus), .o_host_byte_bus_oe_n(oe_n), .o_host_wait_ready(rdy),
		.o_host_interrupt_out_n(host_interrupt_out_n), .i_cpu_req(creq), .i_cpu_we(cwe),
		.i_cpu_addr(caddr), .i_cpu_wdata(cwd), .o_cpu_rdata(crd), .o_cpu_rvalid(rvalid),
		.o_cpu_stall(stall), .o_cpu_interrupt(cint));

	hpp_host_model host_side (.i_clk_sys(clk), .i_dev_byte(dbus), .i_dev_oe_n(oe_n),
		.i_ready(rdy), .o_cs_n(cs_n), .o_ds1_n(ds1_n), .o_ds2_n(ds2_n), .o_bil(bil),
		.o_sel_h(sel_h), .o_sel_l(sel_l), .o_rw(rw), .o_as_n(as_n), .o_bus(hbus));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s finished", name);
	endtask

	// Processor access; stall is read before the edge so a refused request is retried.
	task automatic cpu(input logic we, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic k);
		logic s;
		int   n;
		k = 1'b0;
		q = 'x;
		creq = 1'b1;
		cwe = we;
		caddr = a;
		cwd = d;
		for (n = 0; n < 20 && !k; n++) begin
			s = stall;
			@(posedge clk);
			k = (s === 1'b0);
		end
		@(negedge clk);
		creq = 1'b0;
		for (n = 0; n < 4 && k && !we; n++) begin
			if (rvalid === 1'b1) q = crd;
			@(negedge clk);
		end
	endtask

	task automatic idle_chk();
		chk("reset outputs", 16'h0038, {10'h000, rdy, oe_n, host_interrupt_out_n, stall, cint, rvalid});
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(negedge clk);
		idle_chk();
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		foreach (rows[i]) begin
			if (rows[i].cpu) cpu(!rows[i].rd, rows[i].addr, rows[i].wd, got, ok);
			else host_side.word(rows[i].sel, rows[i].rd, bob, rows[i].wd, got, ok);
			if (!rows[i].cpu && !rows[i].rd && rows[i].sel == SEL_CTRL) bob = rows[i].wd[0];
			chk("handshake", 16'h0001, {15'h0000, ok});
			if (rows[i].rd) chk("row data", rows[i].exp, got);
		end
		chk("ready deselected", 16'h0001, {15'h0000, rdy});
		end_test("table");
		// Interrupts in both directions; the byte order bit is kept at one.
		host_side.word(SEL_CTRL, 1'b0, bob, 16'h0003, got, ok);
		chk("cpu irq set", 16'h0001, {15'h0000, cint});
		cpu(1'b1, CTRL_ADDR, 16'h0007, got, ok);
		repeat (2) @(negedge clk);
		chk("cpu irq clear", 16'h0000, {15'h0000, cint});
		chk("host irq raised", 16'h0000, {15'h0000, host_interrupt_out_n});
		host_side.word(SEL_CTRL, 1'b0, bob, 16'h0005, got, ok);
		chk("host irq ack", 16'h0001, {15'h0000, host_interrupt_out_n});
		end_test("interrupts");
		// Processor reads back to back while the host fetches the same word.
		stalls = 0;
		fork
			host_side.word(SEL_DATA, 1'b1, bob, 16'h0000, got, ok);
			begin
				creq = 1'b1;
				cwe = 1'b0;
				caddr = RAM_BASE + 16'h0013;
				repeat (40) begin
					@(negedge clk);
					if (rvalid === 1'b1) chk("cpu beside host", 16'h5AC3, crd);
				end
				creq = 1'b0;
			end
		join
		chk("host read in conflict", 16'h5AC3, got);
		chk("cpu stalled", 16'h0001, {15'h0000, stalls != 0});
		end_test("conflict");
		// Host-only mode locks the processor out; only reset leaves it.
		cpu(1'b1, CTRL_ADDR, 16'h0009, got, ok);
		repeat (2) @(negedge clk);
		chk("stall host-only", 16'h0001, {15'h0000, stall});
		cpu(1'b0, RAM_BASE + 16'h0013, 16'h0000, got, ok);
		chk("cpu refused", 16'h0000, {15'h0000, ok});
		host_side.word(SEL_DATA, 1'b1, bob, 16'h0000, got, ok);
		chk("host-only read", 16'h5AC3, got);
		end_test("host_only");
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		idle_chk();
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		cpu(1'b0, CTRL_ADDR, 16'h0000, got, ok);
		chk("control after reset", CTRL_RST, got);
		end_test("reset");
		// Multiplexed-bus host: controls are valid only around the address strobe.
		bob = 1'b0;
		host_side.use_as = 1'b1;
		host_side.word(SEL_PTR, 1'b0, bob, 16'h0013, got, ok);
		chk("latched handshake", 16'h0001, {15'h0000, ok});
		host_side.word(SEL_DATA, 1'b1, bob, 16'h0000, got, ok);
		chk("latched read", 16'h5AC3, got);
		end_test("address_strobe");
		report_and_stop();
	end
endmodule // hpp_host_port_tb
